// ---- design/isr_group.sv ----
// one condition/filter/event/enable group with live summary
`timescale 1ns/1ps
`default_nettype none
module isr_group
  import isr_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [CW-1:0] cond_in,
  input wire logic [CW-1:0] defined,
  input wire logic wr_enable,
  input wire logic wr_fall,
  input wire logic wr_rise,
  input wire logic [CW-1:0] wr_data,
  input wire logic rd_event,
  input wire logic clear_event,
  output logic [CW-1:0] cond_q,
  output logic [CW-1:0] event_q,
  output logic [CW-1:0] enable_q,
  output logic [CW-1:0] fall_q,
  output logic [CW-1:0] rise_q,
  output logic summary
);
  typedef struct packed {
    logic [CW-1:0] cond;
    logic [CW-1:0] evt;
    logic [CW-1:0] en;
    logic [CW-1:0] fall;
    logic [CW-1:0] rise;
  } isr_grp_t;
  isr_grp_t s_q, s_d;
  logic [CW-1:0] hit;
  always_comb begin
    s_d = s_q;
    s_d.cond = cond_in & defined;
    // falling edges pass the falling filter, rising edges the rising one
    hit = (s_q.cond & ~s_d.cond & s_q.fall) | (~s_q.cond & s_d.cond & s_q.rise);
    if (wr_enable) s_d.en = wr_data & defined;
    if (wr_fall) s_d.fall = wr_data & defined;
    if (wr_rise) s_d.rise = wr_data & defined;
    // read or clear empties the latch, new edges still land
    if (rd_event || clear_event) s_d.evt = hit;
    else s_d.evt = s_q.evt | hit;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign cond_q = s_q.cond;
  assign event_q = s_q.evt;
  assign enable_q = s_q.en;
  assign fall_q = s_q.fall;
  assign rise_q = s_q.rise;
  assign summary = |(s_q.evt & s_q.en);
endmodule
`default_nettype wire

// ---- design/isr_pkg.sv ----
// constants and types for the instrument status reporting tree
package isr_pkg;
  localparam int NCH = 4;
  localparam int CW = 16;
  // status byte bit positions
  localparam int SB_ERR = 2;
  localparam int SB_FAULT = 3;
  localparam int SB_REPLY = 4;
  localparam int SB_STD = 5;
  localparam int SB_MSS = 6;
  localparam int SB_RUN = 7;
  // standard event bit positions
  localparam int SE_OPS_DONE = 0;
  localparam int SE_READBACK = 2;
  localparam int SE_DEVICE = 3;
  localparam int SE_RUN = 4;
  localparam int SE_SYNTAX = 5;
  localparam int SE_POWER_UP = 7;
  localparam logic [7:0] SE_DEFINED = 8'hbd;
  // fault condition positions
  localparam int FQ_VOLTAGE_LIMIT_TRIP = 0;
  localparam int FQ_CURRENT_LIMIT_TRIP = 1;
  localparam int FQ_MAINS_FAIL_SHUTDOWN = 2;
  localparam int FQ_POSITIVE_POWER_LIMIT = 3;
  localparam int FQ_THERMAL_TRIP = 4;
  localparam int FQ_NEGATIVE_POWER_LIMIT = 5;
  localparam int FQ_EXTERNAL_HOLD_OFF = 9;
  localparam int FQ_REGULATION_LOST = 10;
  localparam int FQ_COUPLED_SHUTDOWN = 11;
  localparam logic [15:0] FQ_DEFINED = 16'h0e3f;
  // run condition positions
  localparam int RC_VOLTAGE_REGULATING = 0;
  localparam int RC_CURRENT_REGULATING = 1;
  localparam int RC_OUTPUT_OFF = 2;
  localparam int RC_MEASURE_ARMED_WAIT = 3;
  localparam int RC_TRANSIENT_ARMED_WAIT = 4;
  localparam logic [15:0] RC_DEFINED = 16'h001f;
  // reset values and the op-complete query reply character
  localparam logic [15:0] RST_MASK16 = 16'h0000;
  localparam logic [7:0] RST_MASK8 = 8'h00;
  localparam logic [7:0] RST_STD_EVENT = 8'h80;
  localparam logic [7:0] ASCII_ONE = 8'h31;
  // register selects of the documented status commands
  typedef enum logic [3:0] {
    RS_RUN_COND = 4'h0, RS_RUN_EVENT = 4'h1, RS_RUN_ENABLE = 4'h2,
    RS_RUN_FALL = 4'h3, RS_RUN_RISE = 4'h4, RS_FAULT_COND = 4'h5,
    RS_FAULT_EVENT = 4'h6, RS_FAULT_ENABLE = 4'h7, RS_FAULT_FALL = 4'h8,
    RS_FAULT_RISE = 4'h9, RS_STD_EVENT = 4'ha, RS_STD_ENABLE = 4'hb,
    RS_SRQ_ENABLE = 4'hc, RS_STATUS_BYTE = 4'hd
  } isr_sel_t;
  typedef enum logic [1:0] {
    SY_IDLE = 2'b00, SY_OPC = 2'b01, SY_OPCQ = 2'b10, SY_WAIT = 2'b11
  } isr_sync_t;
endpackage

// ---- design/isr_top.sv ----
// status reporting tree: per-channel groups, standard events, status byte, sync
`timescale 1ns/1ps
`default_nettype none
module isr_top
  import isr_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [NCH*CW-1:0] run_cond_pins,
  input wire logic [NCH*CW-1:0] fault_cond_pins,
  input wire logic [NCH-1:0] chan_busy_pins,
  input wire logic [1:0] chan_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_sel,
  input wire logic [15:0] reg_wdata,
  input wire logic [7:0] std_event_set,
  input wire logic clear_status,
  input wire logic after_terminator,
  input wire logic ops_done_cmd,
  input wire logic ops_done_query,
  input wire logic wait_cmd,
  input wire logic device_clear,
  input wire logic serial_poll,
  input wire logic out_queue_nonempty,
  input wire logic error_queue_nonempty,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic [7:0] poll_byte,
  output logic poll_valid,
  output logic service_request,
  output logic cmd_stall,
  output logic oq_push,
  output logic [7:0] oq_push_data,
  output logic oq_flush,
  output logic error_queue_clear
);
  typedef struct packed {
    logic [15:0] rdata;
    logic rvalid;
    logic [7:0] poll;
    logic pvalid;
    logic [7:0] std_evt;
    logic [7:0] std_en;
    logic [7:0] srq_en;
    logic svc;
    logic mss_prev;
    logic reply_clr;
    logic stall;
    logic push;
    logic [7:0] push_data;
    logic flush;
    logic err_clr;
    logic [NCH-1:0] busy1;
    logic [NCH-1:0] busy2;
    logic [NCH-1:0] busy3;
    logic [NCH-1:0] busy;
    isr_sync_t sync;
    logic opc_pend;
    logic opcq_pend;
    logic [NCH*CW-1:0] run_p1;
    logic [NCH*CW-1:0] run_p2;
    logic [NCH*CW-1:0] run_p3;
    logic [NCH*CW-1:0] run_ok;
    logic [NCH*CW-1:0] flt_p1;
    logic [NCH*CW-1:0] flt_p2;
    logic [NCH*CW-1:0] flt_p3;
    logic [NCH*CW-1:0] flt_ok;
  } isr_state_t;
  isr_state_t s_q, s_d;
  logic [NCH*CW-1:0] run_cond_v, run_evt_v, run_en_v, run_fall_v, run_rise_v;
  logic [NCH*CW-1:0] flt_cond_v, flt_evt_v, flt_en_v, flt_fall_v, flt_rise_v;
  logic [NCH-1:0] run_sum, flt_sum;
  logic [NCH-1:0] sel_ch;
  logic wr_run_en, wr_run_fall, wr_run_rise, wr_flt_en, wr_flt_fall, wr_flt_rise;
  logic rd_run_evt, rd_flt_evt;
  logic [7:0] stb;
  logic master_summary, all_done;

  function automatic logic [15:0] pick(input logic [NCH*CW-1:0] v, input logic [1:0] ch);
    pick = v[ch*CW +: CW];
  endfunction

  // a captured bit follows only when stages two and three agree
  function automatic logic [NCH*CW-1:0] settle(input logic [NCH*CW-1:0] held,
      input logic [NCH*CW-1:0] s2, input logic [NCH*CW-1:0] s3);
    settle = (held & (s2 ^ s3)) | (s2 & ~(s2 ^ s3));
  endfunction

  assign wr_run_en = reg_wr && (reg_sel == RS_RUN_ENABLE);
  assign wr_run_fall = reg_wr && (reg_sel == RS_RUN_FALL);
  assign wr_run_rise = reg_wr && (reg_sel == RS_RUN_RISE);
  assign wr_flt_en = reg_wr && (reg_sel == RS_FAULT_ENABLE);
  assign wr_flt_fall = reg_wr && (reg_sel == RS_FAULT_FALL);
  assign wr_flt_rise = reg_wr && (reg_sel == RS_FAULT_RISE);
  assign rd_run_evt = reg_rd && (reg_sel == RS_RUN_EVENT);
  assign rd_flt_evt = reg_rd && (reg_sel == RS_FAULT_EVENT);

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign sel_ch[c] = (chan_sel == 2'(c));
    // separate run group for each output channel
    isr_group u_run (
      .clock(clock),
      .sys_rst(sys_rst),
      .cond_in(s_q.run_ok[c*CW +: CW]),
      .defined(RC_DEFINED),
      .wr_enable(wr_run_en && sel_ch[c]),
      .wr_fall(wr_run_fall && sel_ch[c]),
      .wr_rise(wr_run_rise && sel_ch[c]),
      .wr_data(reg_wdata),
      .rd_event(rd_run_evt && sel_ch[c]),
      .clear_event(clear_status),
      .cond_q(run_cond_v[c*CW +: CW]),
      .event_q(run_evt_v[c*CW +: CW]),
      .enable_q(run_en_v[c*CW +: CW]),
      .fall_q(run_fall_v[c*CW +: CW]),
      .rise_q(run_rise_v[c*CW +: CW]),
      .summary(run_sum[c])
    );
    isr_group u_flt (
      .clock(clock),
      .sys_rst(sys_rst),
      .cond_in(s_q.flt_ok[c*CW +: CW]),
      .defined(FQ_DEFINED),
      .wr_enable(wr_flt_en && sel_ch[c]),
      .wr_fall(wr_flt_fall && sel_ch[c]),
      .wr_rise(wr_flt_rise && sel_ch[c]),
      .wr_data(reg_wdata),
      .rd_event(rd_flt_evt && sel_ch[c]),
      .clear_event(clear_status),
      .cond_q(flt_cond_v[c*CW +: CW]),
      .event_q(flt_evt_v[c*CW +: CW]),
      .enable_q(flt_en_v[c*CW +: CW]),
      .fall_q(flt_fall_v[c*CW +: CW]),
      .rise_q(flt_rise_v[c*CW +: CW]),
      .summary(flt_sum[c])
    );
  end

  always_comb begin
    stb = 8'h00;
    stb[SB_RUN] = |run_sum;
    stb[SB_FAULT] = |flt_sum;
    stb[SB_STD] = |(s_q.std_evt & s_q.std_en);
    stb[SB_REPLY] = out_queue_nonempty && !s_q.reply_clr;
    stb[SB_ERR] = error_queue_nonempty;
    master_summary = |(stb & s_q.srq_en);
    stb[SB_MSS] = master_summary;
  end

  assign all_done = ~|s_q.busy;

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.pvalid = 1'b0;
    s_d.push = 1'b0;
    s_d.flush = 1'b0;
    s_d.err_clr = 1'b0;
    s_d.busy1 = chan_busy_pins;
    s_d.busy2 = s_q.busy1;
    s_d.busy3 = s_q.busy2;
    if (s_q.busy2 == s_q.busy3) s_d.busy = s_q.busy2;
    // three-stage capture of the external condition pins
    s_d.run_p1 = run_cond_pins;
    s_d.run_p2 = s_q.run_p1;
    s_d.run_p3 = s_q.run_p2;
    s_d.run_ok = settle(s_q.run_ok, s_q.run_p2, s_q.run_p3);
    s_d.flt_p1 = fault_cond_pins;
    s_d.flt_p2 = s_q.flt_p1;
    s_d.flt_p3 = s_q.flt_p2;
    s_d.flt_ok = settle(s_q.flt_ok, s_q.flt_p2, s_q.flt_p3);
    // register writes
    if (reg_wr && reg_sel == RS_STD_ENABLE) s_d.std_en = reg_wdata[7:0] & SE_DEFINED;
    if (reg_wr && reg_sel == RS_SRQ_ENABLE) s_d.srq_en = reg_wdata[7:0] & ~8'h40;
    // standard events; a read clears, new events in the same cycle still land
    if ((reg_rd && reg_sel == RS_STD_EVENT) || clear_status) s_d.std_evt = 8'h00;
    s_d.std_evt = s_d.std_evt | (std_event_set & SE_DEFINED);
    // register reads
    if (reg_rd) begin
      s_d.rvalid = 1'b1;
      case (reg_sel)
        RS_RUN_COND: s_d.rdata = pick(run_cond_v, chan_sel);
        RS_RUN_EVENT: s_d.rdata = pick(run_evt_v, chan_sel);
        RS_RUN_ENABLE: s_d.rdata = pick(run_en_v, chan_sel);
        RS_RUN_FALL: s_d.rdata = pick(run_fall_v, chan_sel);
        RS_RUN_RISE: s_d.rdata = pick(run_rise_v, chan_sel);
        RS_FAULT_COND: s_d.rdata = pick(flt_cond_v, chan_sel);
        RS_FAULT_EVENT: s_d.rdata = pick(flt_evt_v, chan_sel);
        RS_FAULT_ENABLE: s_d.rdata = pick(flt_en_v, chan_sel);
        RS_FAULT_FALL: s_d.rdata = pick(flt_fall_v, chan_sel);
        RS_FAULT_RISE: s_d.rdata = pick(flt_rise_v, chan_sel);
        RS_STD_EVENT: s_d.rdata = {8'h00, s_q.std_evt};
        RS_STD_ENABLE: s_d.rdata = {8'h00, s_q.std_en};
        RS_SRQ_ENABLE: s_d.rdata = {8'h00, s_q.srq_en};
        // status byte read disturbs nothing, bit 6 is master summary
        RS_STATUS_BYTE: s_d.rdata = {8'h00, stb};
        default: s_d.rdata = 16'h0000;
      endcase
    end
    // service request on master summary rising edge
    s_d.mss_prev = master_summary;
    if (serial_poll) begin
      s_d.poll = {stb[7], s_q.svc, stb[5:0]};
      s_d.pvalid = 1'b1;
      s_d.svc = 1'b0;
    end
    if (master_summary && !s_q.mss_prev) s_d.svc = 1'b1;
    // clear-status
    if (clear_status) begin
      s_d.err_clr = 1'b1;
      s_d.svc = master_summary && !s_q.mss_prev;
      if (after_terminator) begin
        s_d.flush = 1'b1;
        s_d.reply_clr = 1'b1;
      end
    end
    if (!out_queue_nonempty) s_d.reply_clr = 1'b0;
    // completion synchronisation
    if (ops_done_cmd) s_d.opc_pend = 1'b1;
    if (ops_done_query) s_d.opcq_pend = 1'b1;
    case (s_q.sync)
      SY_IDLE: begin
        if (s_q.opc_pend) s_d.sync = SY_OPC;
        else if (s_q.opcq_pend) s_d.sync = SY_OPCQ;
      end
      SY_OPC: begin
        if (all_done) begin
          s_d.std_evt[SE_OPS_DONE] = 1'b1;
          s_d.opc_pend = ops_done_cmd;
          s_d.sync = SY_IDLE;
        end
      end
      SY_OPCQ: begin
        if (all_done) begin
          s_d.push = 1'b1;
          s_d.push_data = ASCII_ONE;
          s_d.opcq_pend = ops_done_query;
          s_d.sync = SY_IDLE;
        end
      end
      SY_WAIT: begin
        if (all_done || device_clear) s_d.sync = SY_IDLE;
      end
      default: s_d.sync = SY_IDLE;
    endcase
    // a wait is never lost behind a pending op-complete, which resumes after
    if (wait_cmd && !device_clear && s_q.sync != SY_WAIT) s_d.sync = SY_WAIT;
    s_d.stall = (s_d.sync == SY_WAIT);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.std_evt <= RST_STD_EVENT;
      s_q.busy <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign poll_byte = s_q.poll;
  assign poll_valid = s_q.pvalid;
  assign service_request = s_q.svc;
  assign cmd_stall = s_q.stall;
  assign oq_push = s_q.push;
  assign oq_push_data = s_q.push_data;
  assign oq_flush = s_q.flush;
  assign error_queue_clear = s_q.err_clr;
endmodule
`default_nettype wire

// ---- dv/isr_ctrl_model.sv ----
// remote controller model: serial polls the device on a service request
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl_model #(parameter int LAG = 3) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic service_request,
  input wire logic poll_valid,
  input wire logic [7:0] poll_byte,
  output logic serial_poll,
  output logic [7:0] last_poll
);
  int wait_cnt;
  initial begin
    serial_poll = 1'b0;
    last_poll = 8'h00;
    wait_cnt = 0;
    forever begin
      @(posedge clock);
      #1;
      // take the answer once it has settled after the edge
      if (poll_valid) last_poll = poll_byte;
      serial_poll = 1'b0;
      // answer a request after a lag, one poll per request
      if (!sys_rst && service_request && wait_cnt < LAG + 2) begin
        wait_cnt = wait_cnt + 1;
        if (wait_cnt == LAG) serial_poll = 1'b1;
      end else if (!service_request) wait_cnt = 0;
    end
  end
endmodule
`default_nettype wire

// ---- dv/isr_props.sv ----
// checker for the status reporting tree ports
`timescale 1ns/1ps
`default_nettype none
module isr_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic serial_poll,
  input wire logic poll_valid,
  input wire logic [7:0] poll_byte,
  input wire logic service_request,
  input wire logic oq_push,
  input wire logic [7:0] oq_push_data,
  input wire logic oq_flush,
  input wire logic clear_status,
  input wire logic after_terminator,
  input wire logic error_queue_clear,
  input wire logic device_clear,
  input wire logic wait_cmd,
  input wire logic cmd_stall
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_read_answers: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_answer_has_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  a_poll_answers: assert property (serial_poll |=> poll_valid ##1 !poll_valid)
    else $error("poll answer not one cycle");
  a_poll_service_bit: assert property (poll_valid |-> poll_byte[6] == $past(service_request))
    else $error("poll bit 6 not latched service bit");
  a_query_char: assert property (oq_push |-> oq_push_data == 8'h31)
    else $error("wrong reply character");
  a_flush_after_term: assert property (clear_status && after_terminator |=> oq_flush)
    else $error("flush missing");
  a_flush_cause: assert property (oq_flush |-> $past(clear_status && after_terminator))
    else $error("flush without terminator clear");
  a_errq_cleared: assert property (clear_status |=> error_queue_clear)
    else $error("error queue not cleared");
  a_clear_ends_wait: assert property (device_clear && !wait_cmd |=> !cmd_stall [*2])
    else $error("device clear did not end wait");
endmodule
bind isr_top isr_props isr_props_i (.clock(clock), .sys_rst(sys_rst), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .serial_poll(serial_poll), .poll_valid(poll_valid),
  .poll_byte(poll_byte), .service_request(service_request), .oq_push(oq_push),
  .oq_push_data(oq_push_data), .oq_flush(oq_flush), .clear_status(clear_status),
  .after_terminator(after_terminator), .error_queue_clear(error_queue_clear),
  .device_clear(device_clear), .wait_cmd(wait_cmd), .cmd_stall(cmd_stall));
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the status reporting tree
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import isr_pkg::*;
  logic clock, sys_rst, reg_wr, reg_rd, clear_status, after_terminator, ops_done_cmd;
  logic ops_done_query, wait_cmd, device_clear, serial_poll, out_queue_nonempty, error_queue_nonempty;
  logic [NCH*CW-1:0] run_cond_pins, fault_cond_pins;
  logic [NCH-1:0] chan_busy_pins;
  logic [1:0] chan_sel;
  logic [3:0] reg_sel;
  logic [15:0] reg_wdata, reg_rdata, rd;
  logic [7:0] std_event_set, poll_byte, oq_push_data, last_poll;
  logic reg_rvalid, poll_valid, service_request, cmd_stall, oq_push, oq_flush, error_queue_clear;
  int fail_count = 0, total_checks = 0, cycles = 0;
  isr_top isr_top_i (.clock(clock), .sys_rst(sys_rst), .run_cond_pins(run_cond_pins),
    .fault_cond_pins(fault_cond_pins), .chan_busy_pins(chan_busy_pins), .chan_sel(chan_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .std_event_set(std_event_set), .clear_status(clear_status),
    .after_terminator(after_terminator), .ops_done_cmd(ops_done_cmd),
    .ops_done_query(ops_done_query), .wait_cmd(wait_cmd), .device_clear(device_clear),
    .serial_poll(serial_poll), .out_queue_nonempty(out_queue_nonempty),
    .error_queue_nonempty(error_queue_nonempty), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .poll_byte(poll_byte), .poll_valid(poll_valid), .service_request(service_request),
    .cmd_stall(cmd_stall), .oq_push(oq_push), .oq_push_data(oq_push_data), .oq_flush(oq_flush),
    .error_queue_clear(error_queue_clear));
  isr_ctrl_model isr_ctrl_model_i (.clock(clock), .sys_rst(sys_rst),
    .service_request(service_request), .poll_valid(poll_valid), .poll_byte(poll_byte),
    .serial_poll(serial_poll), .last_poll(last_poll));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      final_report();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] s, input logic [15:0] d);
    reg_sel = s;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask
  task automatic rdr(input logic [3:0] s);
    reg_sel = s;
    reg_rd = 1'b1;
    step(1);
    // the answer stands for one cycle only
    chk("read valid", {15'h0, reg_rvalid}, 16'h0001);
    rd = reg_rdata;
    reg_rd = 1'b0;
    step(1);
  endtask
  task automatic t_reset();
    rdr(RS_STD_EVENT); chk("std event at power up", rd, 16'h0080);
    rdr(RS_STD_EVENT); chk("std event after read", rd, 16'h0000);
    rdr(RS_SRQ_ENABLE); chk("srq mask reset", rd, 16'h0000);
  endtask
  task automatic t_run_filter();
    chan_sel = 2'd0;
    wr(RS_RUN_RISE, 16'h0001);
    wr(RS_RUN_FALL, 16'h0002);
    wr(RS_RUN_ENABLE, 16'h0002);
    run_cond_pins[15:0] = 16'h0003;
    step(8);
    rdr(RS_RUN_COND); chk("run cond live", rd, 16'h0003);
    run_cond_pins[15:0] = 16'h0000;
    step(8);
    rdr(RS_RUN_COND); chk("run cond live low", rd, 16'h0000);
    rdr(RS_STATUS_BYTE); chk("run summary", rd[7:0] & 8'h80, 8'h80);
    rdr(RS_RUN_EVENT); chk("run event", rd, 16'h0003);
    rdr(RS_RUN_EVENT); chk("run event cleared", rd, 16'h0000);
    rdr(RS_STATUS_BYTE); chk("run summary cleared", rd[7:0] & 8'h80, 8'h00);
  endtask
  task automatic t_fault_srq();
    chan_sel = 2'd1;
    wr(RS_FAULT_RISE, FQ_DEFINED);
    wr(RS_FAULT_ENABLE, 16'h0800);
    wr(RS_SRQ_ENABLE, 16'h0008);
    fault_cond_pins[31:16] = 16'h0810;
    step(12);
    rdr(RS_FAULT_COND); chk("fault cond", rd, 16'h0810);
    chk("poll byte", {8'h0, last_poll}, 16'h0048);
    chk("service after poll", {15'h0, service_request}, 16'h0000);
    rdr(RS_STATUS_BYTE); chk("mss stays", rd[7:0] & 8'h48, 8'h48);
    rdr(RS_FAULT_EVENT); chk("fault event", rd, 16'h0810);
    rdr(RS_FAULT_COND); chk("fault cond kept", rd, 16'h0810);
    rdr(RS_FAULT_EVENT); chk("fault event cleared", rd, 16'h0000);
    wr(RS_SRQ_ENABLE, 16'h0000);
    wr(RS_FAULT_ENABLE, 16'h0005);
    fault_cond_pins[31:16] = 16'h0005;
    step(8);
    rdr(RS_STATUS_BYTE); chk("summary without mask", rd[7:0] & 8'h48, 8'h08);
    chk("no request at zero mask", {15'h0, service_request}, 16'h0000);
    rdr(RS_FAULT_EVENT); chk("fault low bits", rd, 16'h0005);
  endtask
  task automatic t_std_cls();
    wr(RS_STD_ENABLE, 16'h0020);
    rdr(RS_STD_ENABLE); chk("std enable readback", rd, 16'h0020);
    std_event_set = 8'hff;
    step(1);
    std_event_set = 8'h00;
    out_queue_nonempty = 1'b1;
    error_queue_nonempty = 1'b1;
    step(1);
    rdr(RS_STATUS_BYTE); chk("std and reply", rd[7:0] & 8'h34, 8'h34);
    clear_status = 1'b1;
    step(1);
    clear_status = 1'b0;
    rdr(RS_STATUS_BYTE); chk("reply kept by plain clear", rd[7:0] & 8'h34, 8'h14);
    clear_status = 1'b1;
    after_terminator = 1'b1;
    step(1);
    clear_status = 1'b0;
    after_terminator = 1'b0;
    error_queue_nonempty = 1'b0;
    step(1);
    rdr(RS_STATUS_BYTE); chk("cleared byte", rd[7:0] & 8'h3c, 8'h00);
    out_queue_nonempty = 1'b0;
    rdr(RS_STD_EVENT); chk("std cleared", rd, 16'h0000);
  endtask
  task automatic t_sync();
    int n;
    chan_busy_pins = 4'b0100;
    // busy pins need four cycles to reach the pending logic
    step(5);
    ops_done_cmd = 1'b1;
    ops_done_query = 1'b1;
    step(1);
    ops_done_cmd = 1'b0;
    ops_done_query = 1'b0;
    wait_cmd = 1'b1;
    step(1);
    wait_cmd = 1'b0;
    step(10);
    chk("stall while busy", {15'h0, cmd_stall}, 16'h0001);
    rdr(RS_STD_EVENT); chk("no done while busy", rd, 16'h0000);
    chan_busy_pins = 4'b0000;
    n = 0;
    while (!oq_push && n < 40) begin
      step(1);
      n = n + 1;
    end
    chk("reply char", {8'h0, oq_push_data}, 16'h0031);
    step(3);
    chk("stall ended", {15'h0, cmd_stall}, 16'h0000);
    rdr(RS_STD_EVENT); chk("ops done set", rd, 16'h0001);
    chan_busy_pins = 4'b0001;
    step(5);
    wait_cmd = 1'b1;
    step(1);
    wait_cmd = 1'b0;
    step(3);
    chk("stall before clear", {15'h0, cmd_stall}, 16'h0001);
    device_clear = 1'b1;
    step(1);
    device_clear = 1'b0;
    step(1);
    chk("clear cancels wait", {15'h0, cmd_stall}, 16'h0000);
    chan_busy_pins = 4'b0000;
  endtask
  initial begin
    {reg_wr, reg_rd, clear_status, after_terminator, ops_done_cmd, ops_done_query} = '0;
    {wait_cmd, device_clear, out_queue_nonempty, error_queue_nonempty} = '0;
    {run_cond_pins, fault_cond_pins, chan_busy_pins, chan_sel, reg_sel, reg_wdata} = '0;
    std_event_set = 8'h00;
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    t_reset();
    t_run_filter();
    t_fault_srq();
    t_std_cls();
    t_sync();
    final_report();
  end
endmodule
`default_nettype wire
